//--- ccmf_pkg.sv
package ccmf_pkg;

  // Fixed octet values of the congestion message
  localparam logic [12:0] MGMT_DLCI    = 13'h1FFF;
  localparam logic [7:0]  XID_CTRL     = 8'hAF;
  localparam logic [7:0]  FMT_ID       = 8'h83;
  localparam logic [7:0]  GRP_ID       = 8'hFA;
  localparam logic [7:0]  PID_NET      = 8'h01;
  localparam logic [7:0]  PID_DLCI     = 8'h02;
  localparam logic [7:0]  NID_LEN      = 8'h02;

  // Cause codes
  localparam logic [7:0]  CAUSE_NONE   = 8'h00;
  localparam logic [7:0]  CAUSE_INC    = 8'h02;
  localparam logic [7:0]  CAUSE_CLR    = 8'h03;
  localparam logic [7:0]  CAUSE_SUS    = 8'h04;
  localparam logic [7:0]  CAUSE_CRIT   = 8'h06;
  localparam logic [7:0]  CAUSE_CCLR   = 8'h07;
  localparam logic [7:0]  CAUSE_ABATE  = 8'h08;

  // Congestion levels
  localparam logic [1:0]  LVL_NORMAL   = 2'h0;
  localparam logic [1:0]  LVL_MODERATE = 2'h1;
  localparam logic [1:0]  LVL_MAXIMUM  = 2'h2;

  // Frame geometry; positions are 1-based octet numbers
  localparam logic [8:0]  MAX_FRAME    = 9'h104;
  localparam logic [8:0]  POS_DLCI     = 9'h00F;
  localparam logic [8:0]  FRAME_FIXED  = 9'h010;
  localparam logic [8:0]  CNT_CAUSE    = 9'h007;
  localparam logic [6:0]  MAX_DLCI_N   = 7'h7A;
  localparam int          MAX_DLCI     = 122;
  localparam logic [15:0] GLEN_FIXED   = 16'h0007;
  localparam logic [15:0] GLEN_TO_ALL  = 16'h0009;

  // Check sequence, bit-reversed form, low octet sent first
  localparam logic [15:0] CRC_INIT     = 16'hFFFF;
  localparam logic [15:0] CRC_POLY     = 16'h8408;
  localparam logic [15:0] CRC_GOOD     = 16'hF0B8;

  // One octet of check sequence update
  function automatic logic [15:0] ccmf_crc_step(input logic [15:0] crc, input logic [7:0] d);
    logic [15:0] c;
    c = crc ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : ccmf_crc_step

  // Octet at a given position, up to the last identifier entry
  function automatic logic [7:0] ccmf_tx_octet(input logic [8:0]  pos,
                                               input logic        cr,
                                               input logic [7:0]  cause,
                                               input logic [15:0] nid,
                                               input logic [7:0]  dl_len,
                                               input logic [12:0] dlci);
    logic [15:0] glen;
    glen = GLEN_FIXED + {8'h00, dl_len};
    unique case (pos)
      9'h001:  return {MGMT_DLCI[12:7], cr, 1'b0};
      9'h002:  return {MGMT_DLCI[6:0], 1'b1};
      9'h003:  return XID_CTRL;
      9'h004:  return FMT_ID;
      9'h005:  return GRP_ID;
      9'h006:  return glen[15:8];
      9'h007:  return glen[7:0];
      9'h008:  return cause;
      9'h009:  return PID_NET;
      9'h00A:  return NID_LEN;
      9'h00B:  return nid[15:8];
      9'h00C:  return nid[7:0];
      9'h00D:  return PID_DLCI;
      9'h00E:  return dl_len;
      default: return pos[0] ? {dlci[12:7], 2'b00} : {dlci[6:0], 1'b1};
    endcase
  endfunction : ccmf_tx_octet

  // Identifier carried by two address octets
  function automatic logic [12:0] ccmf_addr_dlci(input logic [7:0] o1, input logic [7:0] o2);
    return {o1[7:2], o2[7:1]};
  endfunction : ccmf_addr_dlci

  // Check of the fixed octets at 0-based count cnt
  function automatic logic ccmf_hdr_ok(input logic [8:0] cnt, input logic [7:0] d);
    unique case (cnt)
      9'h000:  return d[7:2] == MGMT_DLCI[12:7] && !d[0];
      9'h001:  return d == {MGMT_DLCI[6:0], 1'b1};
      9'h002:  return d == XID_CTRL;
      9'h003:  return d == FMT_ID;
      9'h004:  return d == GRP_ID;
      default: return 1'b1;
    endcase
  endfunction : ccmf_hdr_ok

  // Cause code is one of the listed values
  function automatic logic ccmf_cause_ok(input logic [7:0] d);
    return d inside {CAUSE_INC, CAUSE_CLR, CAUSE_SUS, CAUSE_CRIT, CAUSE_CCLR, CAUSE_ABATE};
  endfunction : ccmf_cause_ok

endpackage : ccmf_pkg

//--- ccmf_link_if.sv
`timescale 1ns/1ps
interface ccmf_link_if;
  // Octet stream from node to peer
  logic       dn_valid;
  logic [7:0] dn_data;
  logic       dn_last;
  // Octet stream from peer to node
  logic       up_valid;
  logic [7:0] up_data;
  logic       up_last;

  modport node (output dn_valid, output dn_data, output dn_last,
                input  up_valid, input  up_data, input  up_last);
  modport peer (input  dn_valid, input  dn_data, input  dn_last,
                output up_valid, output up_data, output up_last);
endinterface : ccmf_link_if

//--- ccmf_node.sv
`timescale 1ns/1ps
// Overview of operation
// - Octet 1 ones, C/R, bit 1 zero
// - Octet 2 all ones for this message
// - Message always sent on identifier 8191
// - Octet 3 is XID control 0xAF
// - Octet 4 format identifier 131
// - Octet 5 group identifier 250
// - Octets 6-7 count remaining octets before FCS
// - Never exceed 260 octets
// - Octet 8 carries one listed cause code
// - Normal-Moderate increasing, back gives clearing
// - Unchanged Moderate or Maximum gives sustained
// - Rise critical, abating, critical clearing
// - Octet 9 network parameter identifier 1
// - Octet 10 network length, honour any value
// - Network identifier names the originating network
// - Octet 13 identifier-list parameter 2
// - Drop frame lacking identifier-list parameter
// - Octet 14 equals twice identifier count
// - Each identifier two address octets
// - Two FCS octets after last entry
// - 16-bit CRC over whole frame
// - Identifier is 13-bit split address
module ccmf_node
  import ccmf_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  ccmf_link_if.node        lnk,
  input  wire logic        i_measure,
  input  wire logic [1:0]  i_cong_level,
  input  wire logic        i_cmd_resp,
  input  wire logic [15:0] i_net_id,
  input  wire logic        i_dlci_wr,
  input  wire logic [6:0]  i_dlci_idx,
  input  wire logic [12:0] i_dlci_val,
  input  wire logic [6:0]  i_dlci_count,
  output logic             o_tx_busy,
  output logic [7:0]       o_tx_cause,
  input  wire logic [6:0]  i_rx_rd_idx,
  output logic [12:0]      o_rx_dlci,
  output logic             o_rx_ok,
  output logic             o_rx_drop,
  output logic [7:0]       o_rx_cause,
  output logic [15:0]      o_rx_net_id,
  output logic [6:0]       o_rx_dlci_count
);

  typedef enum logic {TX_IDLE, TX_RUN} ccmf_tx_e;
  typedef enum logic [3:0] {RX_HDR, RX_NID_ID, RX_NID_LEN, RX_NID_VAL, RX_DL_ID,
                            RX_DL_LEN, RX_DL_VAL, RX_FCS, RX_BAD} ccmf_rx_e;

  ccmf_tx_e    tx_st;
  logic [1:0]  prev_level;
  logic [1:0]  cur_level;
  logic [7:0]  next_cause;
  logic [6:0]  req_n;
  logic [8:0]  tx_pos;
  logic [8:0]  tx_end;
  logic [15:0] tx_crc;
  logic [15:0] tx_nid;
  logic [6:0]  tx_n;
  logic        tx_cr;
  logic [8:0]  dl_idx;
  logic [12:0] dl_word;
  logic [7:0]  tx_byte;
  logic        dn_valid;
  logic [7:0]  dn_data;
  logic        dn_last;
  logic [12:0] tx_mem [MAX_DLCI];
  logic [12:0] rx_mem [MAX_DLCI];

  ccmf_rx_e    rx_st;
  logic [8:0]  rx_cnt;
  logic [7:0]  rx_rem;
  logic [15:0] rx_crc;
  logic [15:0] rx_crc_nx;
  logic [15:0] rx_glen;
  logic [7:0]  rx_cause;
  logic [15:0] rx_nid;
  logic [6:0]  rx_n;
  logic [7:0]  rx_hi;
  logic        rx_fcs2;
  logic        fin_ok;

  // Cause from previous and present level
  function automatic logic [7:0] pick_cause(input logic [1:0] p, input logic [1:0] c);
    unique case ({p, c})
      {LVL_NORMAL, LVL_MODERATE}:   return CAUSE_INC;
      {LVL_MODERATE, LVL_NORMAL}:   return CAUSE_CLR;
      {LVL_MODERATE, LVL_MODERATE}: return CAUSE_SUS;
      {LVL_MAXIMUM, LVL_MAXIMUM}:   return CAUSE_SUS;
      {LVL_NORMAL, LVL_MAXIMUM}:    return CAUSE_CRIT;
      {LVL_MODERATE, LVL_MAXIMUM}:  return CAUSE_CRIT;
      {LVL_MAXIMUM, LVL_MODERATE}:  return CAUSE_ABATE;
      {LVL_MAXIMUM, LVL_NORMAL}:    return CAUSE_CCLR;
      default:                      return CAUSE_NONE;
    endcase
  endfunction : pick_cause

  // Level 3 is taken as Maximum; list size clamped to the frame limit
  always_comb begin
    cur_level  = (i_cong_level > LVL_MAXIMUM) ? LVL_MAXIMUM : i_cong_level;
    next_cause = pick_cause(prev_level, cur_level);
    req_n      = (i_dlci_count > MAX_DLCI_N) ? MAX_DLCI_N : i_dlci_count;
  end

  // Transmit identifier table
  always_ff @(posedge i_sys_clk) begin
    if (i_dlci_wr && i_dlci_idx < MAX_DLCI_N) begin
      tx_mem[i_dlci_idx] <= i_dlci_val;
    end
  end

  // Octet for the present transmit position
  always_comb begin
    dl_idx  = tx_pos - POS_DLCI;
    dl_word = '0;
    if (tx_pos >= POS_DLCI && dl_idx[8:1] < {1'b0, MAX_DLCI_N}) begin
      dl_word = tx_mem[dl_idx[7:1]];
    end
    tx_byte = ccmf_tx_octet(tx_pos, tx_cr, o_tx_cause, tx_nid, {tx_n, 1'b0}, dl_word);
  end

  // Level seen at the last measurement taken while idle
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      prev_level <= LVL_NORMAL;
    end else if (i_measure && tx_st == TX_IDLE) begin
      prev_level <= cur_level;
    end
  end

  // Transmit sequencer
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_st      <= TX_IDLE;
      tx_pos     <= 9'h001;
      tx_end     <= FRAME_FIXED;
      tx_crc     <= CRC_INIT;
      tx_nid     <= 16'h0000;
      tx_n       <= 7'h00;
      tx_cr      <= 1'b0;
      o_tx_cause <= CAUSE_NONE;
      dn_valid   <= 1'b0;
      dn_data    <= 8'h00;
      dn_last    <= 1'b0;
    end else begin
      dn_valid <= 1'b0;
      dn_last  <= 1'b0;
      unique case (tx_st)
        TX_IDLE: begin
          if (i_measure && next_cause != CAUSE_NONE) begin
            o_tx_cause <= next_cause;
            tx_nid     <= i_net_id;
            tx_n       <= req_n;
            tx_cr      <= i_cmd_resp;
            tx_end     <= FRAME_FIXED + {1'b0, req_n, 1'b0};
            tx_pos     <= 9'h001;
            tx_crc     <= CRC_INIT;
            tx_st      <= TX_RUN;
          end
        end
        TX_RUN: begin
          dn_valid <= 1'b1;
          tx_pos   <= tx_pos + 9'h001;
          if (tx_pos < tx_end - 9'h001) begin
            dn_data <= tx_byte;
            tx_crc  <= ccmf_crc_step(tx_crc, tx_byte);
          end else if (tx_pos == tx_end - 9'h001) begin
            dn_data <= ~tx_crc[7:0];
          end else begin
            dn_data <= ~tx_crc[15:8];
            dn_last <= 1'b1;
            tx_st   <= TX_IDLE;
          end
        end
      endcase
    end
  end

  assign lnk.dn_valid = dn_valid;
  assign lnk.dn_data  = dn_data;
  assign lnk.dn_last  = dn_last;
  assign o_tx_busy    = (tx_st == TX_RUN);

  // End-of-frame acceptance test
  always_comb begin
    rx_crc_nx = ccmf_crc_step(rx_crc, lnk.up_data);
    fin_ok    = rx_st == RX_FCS && rx_fcs2 && rx_crc_nx == CRC_GOOD
                && ({7'h00, rx_cnt} + 16'h0001) == (rx_glen + GLEN_TO_ALL);
  end

  // Receive parser
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_st    <= RX_HDR;
      rx_cnt   <= 9'h000;
      rx_rem   <= 8'h00;
      rx_crc   <= CRC_INIT;
      rx_glen  <= 16'h0000;
      rx_cause <= CAUSE_NONE;
      rx_nid   <= 16'h0000;
      rx_n     <= 7'h00;
      rx_hi    <= 8'h00;
      rx_fcs2  <= 1'b0;
    end else if (lnk.up_valid) begin
      rx_cnt <= rx_cnt + 9'h001;
      rx_crc <= rx_crc_nx;
      unique case (rx_st)
        RX_HDR: begin
          if (!ccmf_hdr_ok(rx_cnt, lnk.up_data)) rx_st <= RX_BAD;
          if (rx_cnt == 9'h000) rx_n <= 7'h00;
          if (rx_cnt == 9'h005) rx_glen[15:8] <= lnk.up_data;
          if (rx_cnt == 9'h006) rx_glen[7:0] <= lnk.up_data;
          if (rx_cnt == CNT_CAUSE) begin
            rx_cause <= lnk.up_data;
            rx_st    <= ccmf_cause_ok(lnk.up_data) ? RX_NID_ID : RX_BAD;
          end
        end
        RX_NID_ID:  rx_st <= (lnk.up_data == PID_NET) ? RX_NID_LEN : RX_BAD;
        RX_NID_LEN: begin
          rx_rem <= lnk.up_data;
          rx_nid <= 16'h0000;
          rx_st  <= (lnk.up_data == 8'h00) ? RX_DL_ID : RX_NID_VAL;
        end
        RX_NID_VAL: begin
          rx_nid <= {rx_nid[7:0], lnk.up_data};
          rx_rem <= rx_rem - 8'h01;
          if (rx_rem == 8'h01) rx_st <= RX_DL_ID;
        end
        RX_DL_ID:   rx_st <= (lnk.up_data == PID_DLCI) ? RX_DL_LEN : RX_BAD;
        RX_DL_LEN: begin
          rx_rem <= lnk.up_data;
          if (lnk.up_data[0] || lnk.up_data > {MAX_DLCI_N, 1'b0}) rx_st <= RX_BAD;
          else if (lnk.up_data == 8'h00) rx_st <= RX_FCS;
          else rx_st <= RX_DL_VAL;
        end
        RX_DL_VAL: begin
          rx_rem <= rx_rem - 8'h01;
          if (!rx_rem[0]) begin
            rx_hi <= lnk.up_data;
          end else begin
            rx_mem[rx_n] <= ccmf_addr_dlci(rx_hi, lnk.up_data);
            rx_n         <= rx_n + 7'h01;
          end
          if (rx_rem == 8'h01) rx_st <= RX_FCS;
        end
        RX_FCS: begin
          if (rx_fcs2) rx_st <= RX_BAD;
          rx_fcs2 <= 1'b1;
        end
        default: rx_st <= RX_BAD;
      endcase
      if (rx_cnt >= MAX_FRAME - 9'h001) rx_st <= RX_BAD;
      if (lnk.up_last) begin
        rx_st   <= RX_HDR;
        rx_cnt  <= 9'h000;
        rx_crc  <= CRC_INIT;
        rx_fcs2 <= 1'b0;
      end
    end
  end

  // Verdict pulses and fields of the last good frame
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_ok         <= 1'b0;
      o_rx_drop       <= 1'b0;
      o_rx_cause      <= CAUSE_NONE;
      o_rx_net_id     <= 16'h0000;
      o_rx_dlci_count <= 7'h00;
    end else begin
      o_rx_ok   <= lnk.up_valid && lnk.up_last && fin_ok;
      o_rx_drop <= lnk.up_valid && lnk.up_last && !fin_ok;
      if (lnk.up_valid && lnk.up_last && fin_ok) begin
        o_rx_cause      <= rx_cause;
        o_rx_net_id     <= rx_nid;
        o_rx_dlci_count <= rx_n;
      end
    end
  end

  // Received identifier read port
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rx_dlci <= 13'h0000;
    end else begin
      o_rx_dlci <= (i_rx_rd_idx < MAX_DLCI_N) ? rx_mem[i_rx_rd_idx] : 13'h0000;
    end
  end

endmodule : ccmf_node

//--- ccmf_peer.sv
`timescale 1ns/1ps
module ccmf_peer
  import ccmf_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  ccmf_link_if.peer        lnk,
  input  wire logic        i_send,
  input  wire logic [7:0]  i_cause,
  input  wire logic        i_cmd_resp,
  input  wire logic [15:0] i_net_id,
  input  wire logic        i_dlci_wr,
  input  wire logic [6:0]  i_dlci_idx,
  input  wire logic [12:0] i_dlci_val,
  input  wire logic [6:0]  i_dlci_count,
  output logic             o_tx_busy,
  output logic             o_rx_dlci_valid,
  output logic [12:0]      o_rx_dlci,
  output logic             o_rx_done,
  output logic             o_rx_good,
  output logic [7:0]       o_rx_cause,
  output logic [15:0]      o_rx_net_id
);

  typedef enum logic {PT_IDLE, PT_RUN} ccmf_ptx_e;
  typedef enum logic [2:0] {PR_HDR, PR_NID, PR_DLID, PR_DLLEN, PR_DL, PR_FCS, PR_BAD} ccmf_prx_e;

  ccmf_ptx_e   tx_st;
  logic [8:0]  tx_pos;
  logic [8:0]  tx_end;
  logic [15:0] tx_crc;
  logic [15:0] tx_nid;
  logic [7:0]  tx_cause;
  logic [6:0]  tx_n;
  logic        tx_cr;
  logic [8:0]  dl_idx;
  logic [12:0] dl_word;
  logic [7:0]  tx_byte;
  logic        up_valid;
  logic [7:0]  up_data;
  logic        up_last;
  logic [12:0] tx_mem [MAX_DLCI];

  ccmf_prx_e   rx_st;
  logic [8:0]  rx_cnt;
  logic [7:0]  rx_rem;
  logic [15:0] rx_crc;
  logic [15:0] rx_crc_nx;
  logic [15:0] rx_glen;
  logic [7:0]  rx_hi;
  logic        rx_fcs2;
  logic        fin_ok;

  // Transmit identifier table
  always_ff @(posedge i_sys_clk) begin
    if (i_dlci_wr && i_dlci_idx < MAX_DLCI_N) begin
      tx_mem[i_dlci_idx] <= i_dlci_val;
    end
  end

  // Octet for the present transmit position
  always_comb begin
    dl_idx  = tx_pos - POS_DLCI;
    dl_word = '0;
    if (tx_pos >= POS_DLCI && dl_idx[8:1] < {1'b0, MAX_DLCI_N}) begin
      dl_word = tx_mem[dl_idx[7:1]];
    end
    tx_byte = ccmf_tx_octet(tx_pos, tx_cr, tx_cause, tx_nid, {tx_n, 1'b0}, dl_word);
  end

  // Transmit sequencer
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_st    <= PT_IDLE;
      tx_pos   <= 9'h001;
      tx_end   <= FRAME_FIXED;
      tx_crc   <= CRC_INIT;
      tx_nid   <= 16'h0000;
      tx_cause <= CAUSE_NONE;
      tx_n     <= 7'h00;
      tx_cr    <= 1'b0;
      up_valid <= 1'b0;
      up_data  <= 8'h00;
      up_last  <= 1'b0;
    end else begin
      up_valid <= 1'b0;
      up_last  <= 1'b0;
      unique case (tx_st)
        PT_IDLE: begin
          if (i_send) begin
            tx_cause <= i_cause;
            tx_nid   <= i_net_id;
            tx_n     <= (i_dlci_count > MAX_DLCI_N) ? MAX_DLCI_N : i_dlci_count;
            tx_cr    <= i_cmd_resp;
            tx_end   <= FRAME_FIXED + ((i_dlci_count > MAX_DLCI_N) ?
                        {1'b0, MAX_DLCI_N, 1'b0} : {1'b0, i_dlci_count, 1'b0});
            tx_pos   <= 9'h001;
            tx_crc   <= CRC_INIT;
            tx_st    <= PT_RUN;
          end
        end
        PT_RUN: begin
          up_valid <= 1'b1;
          tx_pos   <= tx_pos + 9'h001;
          if (tx_pos < tx_end - 9'h001) begin
            up_data <= tx_byte;
            tx_crc  <= ccmf_crc_step(tx_crc, tx_byte);
          end else if (tx_pos == tx_end - 9'h001) begin
            up_data <= ~tx_crc[7:0];
          end else begin
            up_data <= ~tx_crc[15:8];
            up_last <= 1'b1;
            tx_st   <= PT_IDLE;
          end
        end
      endcase
    end
  end

  assign lnk.up_valid = up_valid;
  assign lnk.up_data  = up_data;
  assign lnk.up_last  = up_last;
  assign o_tx_busy    = (tx_st == PT_RUN);

  // End-of-frame test
  always_comb begin
    rx_crc_nx = ccmf_crc_step(rx_crc, lnk.dn_data);
    fin_ok    = rx_st == PR_FCS && rx_fcs2 && rx_crc_nx == CRC_GOOD
                && ({7'h00, rx_cnt} + 16'h0001) == (rx_glen + GLEN_TO_ALL);
  end

  // Receive parser; identifiers stream out as they arrive
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rx_st           <= PR_HDR;
      rx_cnt          <= 9'h000;
      rx_rem          <= 8'h00;
      rx_crc          <= CRC_INIT;
      rx_glen         <= 16'h0000;
      rx_hi           <= 8'h00;
      rx_fcs2         <= 1'b0;
      o_rx_dlci_valid <= 1'b0;
      o_rx_dlci       <= 13'h0000;
      o_rx_done       <= 1'b0;
      o_rx_good       <= 1'b0;
      o_rx_cause      <= CAUSE_NONE;
      o_rx_net_id     <= 16'h0000;
    end else begin
      o_rx_dlci_valid <= 1'b0;
      o_rx_done       <= 1'b0;
      if (lnk.dn_valid) begin
        rx_cnt <= rx_cnt + 9'h001;
        rx_crc <= rx_crc_nx;
        unique case (rx_st)
          PR_HDR: begin
            if (!ccmf_hdr_ok(rx_cnt, lnk.dn_data)) rx_st <= PR_BAD;
            if (rx_cnt == 9'h005) rx_glen[15:8] <= lnk.dn_data;
            if (rx_cnt == 9'h006) rx_glen[7:0] <= lnk.dn_data;
            if (rx_cnt == CNT_CAUSE) o_rx_cause <= lnk.dn_data;
            if (rx_cnt == 9'h008 && lnk.dn_data != PID_NET) rx_st <= PR_BAD;
            if (rx_cnt == 9'h009) begin
              rx_rem      <= lnk.dn_data;
              o_rx_net_id <= 16'h0000;
              rx_st       <= (lnk.dn_data == 8'h00) ? PR_DLID : PR_NID;
            end
          end
          PR_NID: begin
            o_rx_net_id <= {o_rx_net_id[7:0], lnk.dn_data};
            rx_rem      <= rx_rem - 8'h01;
            if (rx_rem == 8'h01) rx_st <= PR_DLID;
          end
          PR_DLID:  rx_st <= (lnk.dn_data == PID_DLCI) ? PR_DLLEN : PR_BAD;
          PR_DLLEN: begin
            rx_rem <= lnk.dn_data;
            if (lnk.dn_data[0]) rx_st <= PR_BAD;
            else rx_st <= (lnk.dn_data == 8'h00) ? PR_FCS : PR_DL;
          end
          PR_DL: begin
            rx_rem <= rx_rem - 8'h01;
            if (!rx_rem[0]) begin
              rx_hi <= lnk.dn_data;
            end else begin
              o_rx_dlci       <= ccmf_addr_dlci(rx_hi, lnk.dn_data);
              o_rx_dlci_valid <= 1'b1;
            end
            if (rx_rem == 8'h01) rx_st <= PR_FCS;
          end
          PR_FCS: begin
            if (rx_fcs2) rx_st <= PR_BAD;
            rx_fcs2 <= 1'b1;
          end
          default: rx_st <= PR_BAD;
        endcase
        if (rx_cnt >= MAX_FRAME - 9'h001) rx_st <= PR_BAD;
        if (lnk.dn_last) begin
          o_rx_done <= 1'b1;
          o_rx_good <= fin_ok;
          rx_st     <= PR_HDR;
          rx_cnt    <= 9'h000;
          rx_crc    <= CRC_INIT;
          rx_fcs2   <= 1'b0;
        end
      end
    end
  end

endmodule : ccmf_peer

//--- ccmf_link_sva.sv
`timescale 1ns/1ps
module ccmf_link_sva (
  input wire logic       i_sys_clk,
  input wire logic       i_rst,
  input wire logic       dn_valid,
  input wire logic [7:0] dn_data,
  input wire logic       dn_last
);
  logic [8:0] pos;
  wire logic [9:0] at = {dn_valid, pos};
  // Octet position on the node-to-peer stream
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst)
      pos <= 9'h000;
    else if (dn_valid)
      pos <= dn_last ? 9'h000 : pos + 9'h001;
  end
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  addr_hi_a: assert property (at == 10'h200 |-> dn_data[7:2] == 6'h3F && !dn_data[0])
    else $error("octet 1");
  addr_lo_a: assert property (at == 10'h201 |-> dn_data == 8'hFF)
    else $error("octet 2");
  xid_ctl_a: assert property (at == 10'h202 |-> dn_data == 8'hAF)
    else $error("octet 3");
  fmt_id_a: assert property (at == 10'h203 |-> dn_data == 8'h83)
    else $error("octet 4");
  grp_id_a: assert property (at == 10'h204 |-> dn_data == 8'hFA)
    else $error("octet 5");
  cause_a: assert property (at == 10'h207 |->
    dn_data inside {8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h08})
    else $error("octet 8");
  net_pid_a: assert property (at == 10'h208 |-> dn_data == 8'h01)
    else $error("octet 9");
  list_pid_a: assert property (at == 10'h20C |-> dn_data == 8'h02)
    else $error("octet 13");
  max_len_a: assert property (dn_valid |-> pos < 9'h104)
    else $error("frame too long");
  frame_end_a: assert property ($fell(dn_valid) |-> $past(dn_last))
    else $error("frame cut short");
endmodule : ccmf_link_sva

//--- congestion_msg_framer_tb.sv
`timescale 1ns/1ps
module congestion_msg_framer_tb;
  import ccmf_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        meas = 1'b0, send = 1'b0, nwr = 1'b0, pwr = 1'b0, cr = 1'b1;
  logic        ok, drop, done, good, busy, dv;
  logic [1:0]  lvl = 2'h0;
  logic [7:0]  cause = 8'h00, rxc, pc, txc;
  logic [15:0] nid = 16'hA5C3, rxn, pn;
  logic [6:0]  idx = 7'h00, rd = 7'h00, ncnt = 7'h01, pcnt = 7'h02, rxcnt;
  logic [12:0] val = 13'h0000, rxd, pdl;
  int          n_errors = 0, n_tests = 0, cyc = 0, nv = 0;
  ccmf_link_if lnk ();
  ccmf_node u_ccmf_node (.i_sys_clk(clk), .i_rst(rst), .lnk(lnk), .i_measure(meas),
    .i_cong_level(lvl), .i_cmd_resp(cr), .i_net_id(nid), .i_dlci_wr(nwr), .i_dlci_idx(idx),
    .i_dlci_val(val), .i_dlci_count(ncnt), .o_tx_busy(busy), .o_tx_cause(txc),
    .i_rx_rd_idx(rd),
    .o_rx_dlci(rxd), .o_rx_ok(ok), .o_rx_drop(drop), .o_rx_cause(rxc), .o_rx_net_id(rxn),
    .o_rx_dlci_count(rxcnt));
  ccmf_peer u_ccmf_peer (.i_sys_clk(clk), .i_rst(rst), .lnk(lnk), .i_send(send),
    .i_cause(cause), .i_cmd_resp(cr), .i_net_id(nid), .i_dlci_wr(pwr), .i_dlci_idx(idx),
    .i_dlci_val(val), .i_dlci_count(pcnt), .o_tx_busy(), .o_rx_dlci_valid(dv), .o_rx_dlci(pdl),
    .o_rx_done(done), .o_rx_good(good), .o_rx_cause(pc), .o_rx_net_id(pn));
  ccmf_link_sva u_ccmf_link_sva (.i_sys_clk(clk), .i_rst(rst), .dn_valid(lnk.dn_valid),
    .dn_data(lnk.dn_data), .dn_last(lnk.dn_last));
  always #5 clk = ~clk;
  // Identifiers streamed out by the peer
  always @(posedge clk) begin
    if (dv) nv++;
  end
  // Cycle ceiling against hangs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude
  // One identifier table entry, peer or node side
  task automatic wr(input logic p, input logic [6:0] i, input logic [12:0] v);
    @(posedge clk);
    idx <= i;
    val <= v;
    nwr <= !p;
    pwr <= p;
    @(posedge clk);
    nwr <= 1'b0;
    pwr <= 1'b0;
  endtask : wr
  // Every level change from the node, decoded by the peer
  task automatic cause_walk();
    logic [1:0] lv[8] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h1, 2'h0, 2'h2, 2'h0};
    logic [7:0] ex[8] = '{CAUSE_INC, CAUSE_SUS, CAUSE_CRIT, CAUSE_SUS, CAUSE_ABATE,
                          CAUSE_CLR, CAUSE_CRIT, CAUSE_CCLR};
    for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      meas <= 1'b1;
      lvl <= lv[k];
      @(posedge clk);
      meas <= 1'b0;
      @(posedge clk);
      chk(busy, 1'b1);
      @(posedge clk iff done);
      chk(pc, ex[k]);
      chk(txc, ex[k]);
      chk(nv[15:0], 16'(k + 1));
      chk(good, 1'b1);
      chk(pdl, 13'h1234);
      chk(pn, nid);
    end
  endtask : cause_walk
  // Peer frame into the node; a cause off the list is dropped
  task automatic peer_send(input logic [7:0] c, input logic e);
    @(posedge clk);
    send <= 1'b1;
    cause <= c;
    @(posedge clk);
    send <= 1'b0;
    @(posedge clk iff (ok || drop));
    chk(ok, e);
    if (e) begin
      chk(rxc, c);
      chk(rxn, nid);
      chk(rxcnt, 7'h02);
      for (int k = 0; k < 2; k++) begin
        rd <= k[6:0];
        repeat (2) @(posedge clk);
        chk(rxd, k ? 13'h1AAA : 13'h0555);
      end
    end
  endtask : peer_send
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wr(1'b0, 7'h00, 13'h1234);
    wr(1'b1, 7'h00, 13'h0555);
    wr(1'b1, 7'h01, 13'h1AAA);
    cause_walk();
    peer_send(CAUSE_SUS, 1'b1);
    peer_send(8'h05, 1'b0);
    conclude();
  end
endmodule : congestion_msg_framer_tb
